// ### seq_defs.vh
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

// Command word layout (bit 0 is the low end)
`define CMD_WIDTH       15
`define ADDR_LSB        0
`define ADDR_BITS       5
`define CMDB_LSB        5
`define CMDB_BITS       8
`define READ_BIT        13
`define RESET_BIT       14

// Timing, in milliseconds
`define SETTLE_MS       18
`define READ_HOLD_MS    25
`define RELEASE_MS      18

// Clock figures
`define CLK_HZ          100000000
`define CYC_PER_MS      (`CLK_HZ / 1000)

// Reset values
`define CMD_RESET       15'h0000

`endif

// ### ms_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "seq_defs.vh"

// Millisecond tick divider
module ms_tick #(
  parameter integer CYC_PER_MS = `CYC_PER_MS
) (
  input  wire mclk_in,
  input  wire nrst_in,
  output reg  tick_out
);

  reg [31:0] cnt_q;

  // Free-running divider, one-cycle pulse per millisecond
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      cnt_q    <= 32'h00000000;
      tick_out <= 1'b0;
    end else if (cnt_q == CYC_PER_MS - 1) begin
      cnt_q    <= 32'h00000000;
      tick_out <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 32'h00000001;
      tick_out <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### stage_switch_command_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "seq_defs.vh"

module stage_switch_command_sequencer #(
  parameter integer CYC_PER_MS   = `CYC_PER_MS,
  parameter integer SETTLE_MS    = `SETTLE_MS,
  parameter integer READ_HOLD_MS = `READ_HOLD_MS,
  parameter integer RELEASE_MS   = `RELEASE_MS
) (
  input  wire        mclk_in,
  input  wire        nrst_in,
  input  wire        start_in,
  input  wire [4:0]  stage_sel_in,
  input  wire [7:0]  command_in,
  input  wire [7:0]  feedback_in,
  input  wire        hung_in,
  output reg  [14:0] stage_cmd_out,
  output reg         busy_out,
  output reg         done_out,
  output reg         mismatch_out,
  output reg         hung_out,
  output reg         bad_sel_out
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [3:0] ST_IDLE    = 4'h0;
  localparam [3:0] ST_SETTLE  = 4'h1;
  localparam [3:0] ST_CHECK   = 4'h2;
  localparam [3:0] ST_READ    = 4'h3;
  localparam [3:0] ST_RELEASE = 4'h4;
  localparam [3:0] ST_COMP    = 4'h5;
  localparam [3:0] ST_DONE    = 4'h6;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Echo lines are only compared long after the word has settled,
  // so per-bit capture needs no word handshake
  wire [`CMDB_BITS-1:0] fb_sync;
  reg                   hung_s1_q;
  reg                   hung_s2_q;

  genvar g;

  // Two-stage capture of each unit feedback line
  generate
    for (g = 0; g < `CMDB_BITS; g = g + 1) begin : g_fb_sync
      reg s1_q;
      reg s2_q;
      always @(posedge mclk_in) begin
        if (!nrst_in) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= feedback_in[g];
          s2_q <= s1_q;
        end
      end
      assign fb_sync[g] = s2_q;
    end
  endgenerate

  // Two-stage capture of the hung indication
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      hung_s1_q <= 1'b0;
      hung_s2_q <= 1'b0;
    end else begin
      hung_s1_q <= hung_in;
      hung_s2_q <= hung_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Millisecond timebase
  // ------------------------------------------------------------
  wire ms_tick;

  ms_tick #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_tick (
    .mclk_in  (mclk_in),
    .nrst_in  (nrst_in),
    .tick_out (ms_tick)
  );

  // ------------------------------------------------------------
  // One-hot address check
  // ------------------------------------------------------------
  wire [2:0] ones_acc [0:`ADDR_BITS];

  assign ones_acc[0] = 3'h0;

  // Running count of set address bits, one adder per bit
  generate
    for (g = 0; g < `ADDR_BITS; g = g + 1) begin : g_ones
      assign ones_acc[g+1] = ones_acc[g] + {2'h0, stage_sel_in[g]};
    end
  endgenerate

  // Exactly one stage may be addressed per command
  wire sel_ok = (ones_acc[`ADDR_BITS] == 3'h1);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  reg [3:0] state_q;
  reg [7:0] cmd_q;
  reg [4:0] addr_q;
  reg [7:0] ms_q;
  reg       recov_q;

  // Full waits count whole ticks plus one to cover a partial first ms
  wire [7:0] settle_n  = SETTLE_MS[7:0] + 8'h01;
  wire [7:0] hold_n    = READ_HOLD_MS[7:0] + 8'h01;
  wire [7:0] release_n = RELEASE_MS[7:0] + 8'h01;
  wire       ms_hit    = ms_tick && (ms_q == 8'h01);

  // ------------------------------------------------------------
  // Phase decode
  // ------------------------------------------------------------
  wire in_idle  = (state_q == ST_IDLE);
  wire attempt  = in_idle && start_in;             // Start request while in idle
  wire accept   = attempt && !hung_s2_q && sel_ok;
  wire fb_ok    = (fb_sync == ~cmd_q);
  wire mis_seen = (state_q == ST_CHECK) && !fb_ok && !recov_q;

  // ------------------------------------------------------------
  // Wait timer
  // ------------------------------------------------------------
  reg       wait_load;
  reg [7:0] wait_val;

  // Reload value for the phase being entered
  always @* begin
    wait_load = 1'b0;
    wait_val  = 8'h00;
    case (state_q)
      ST_IDLE: begin
        wait_load = accept;
        wait_val  = settle_n;
      end
      ST_CHECK: begin
        wait_load = 1'b1;
        wait_val  = (fb_ok || recov_q) ? hold_n : release_n;
      end
      ST_RELEASE: begin
        wait_load = ms_hit;
        wait_val  = settle_n;
      end
      default: begin
        wait_load = 1'b0;
        wait_val  = 8'h00;
      end
    endcase
  end

  // Countdown in whole milliseconds; a reload takes priority
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      ms_q <= 8'h00;
    end else if (wait_load) begin
      ms_q <= wait_val;
    end else if (ms_tick && ms_q != 8'h00) begin
      ms_q <= ms_q - 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Phase words
  // ------------------------------------------------------------
  reg [`CMD_WIDTH-1:0] word_load;
  reg [`CMD_WIDTH-1:0] word_read;
  reg [`CMD_WIDTH-1:0] word_reset;
  reg [`CMD_WIDTH-1:0] word_comp;

  // Field placement for each phase; unused fields stay zero
  always @* begin
    word_load  = `CMD_RESET;
    word_read  = `CMD_RESET;
    word_reset = `CMD_RESET;
    word_comp  = `CMD_RESET;
    // Address and command, read and reset clear
    word_load[`ADDR_LSB +: `ADDR_BITS] = stage_sel_in;
    word_load[`CMDB_LSB +: `CMDB_BITS] = command_in;
    // Address kept for telemetry, read bit set
    word_read[`ADDR_LSB +: `ADDR_BITS] = addr_q;
    word_read[`READ_BIT]               = 1'b1;
    // Reset bit alone
    word_reset[`RESET_BIT]             = 1'b1;
    // Complemented command on the same stage
    word_comp[`ADDR_LSB +: `ADDR_BITS] = addr_q;
    word_comp[`CMDB_LSB +: `CMDB_BITS] = ~cmd_q;
  end

  // ------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------
  // Attempt results are replaced at every start request made in idle; the mismatch
  // flag is cleared only by the next accepted start, and a set in the
  // same cycle as a clear wins
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      hung_out     <= 1'b0;
      bad_sel_out  <= 1'b0;
      mismatch_out <= 1'b0;
    end else begin
      if (attempt) begin
        hung_out    <= hung_s2_q;
        bad_sel_out <= !sel_ok;
      end
      if (mis_seen) begin
        mismatch_out <= 1'b1;
      end else if (accept) begin
        mismatch_out <= 1'b0;
      end
    end
  end

  // Main handshake sequence
  always @(posedge mclk_in) begin
    if (!nrst_in) begin
      state_q       <= ST_IDLE;
      cmd_q         <= 8'h00;
      addr_q        <= 5'h00;
      recov_q       <= 1'b0;
      stage_cmd_out <= `CMD_RESET;
      busy_out      <= 1'b0;
      done_out      <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          busy_out <= 1'b0;
          if (attempt && hung_s2_q) begin
            stage_cmd_out <= `CMD_RESET;
          end else if (accept) begin
            cmd_q         <= command_in;
            addr_q        <= stage_sel_in;
            recov_q       <= 1'b0;
            busy_out      <= 1'b1;
            stage_cmd_out <= word_load;
            state_q       <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (ms_hit) begin
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (fb_ok) begin
            stage_cmd_out <= word_read;
            state_q       <= ST_READ;
          end else if (!recov_q) begin
            stage_cmd_out <= word_reset;
            state_q       <= ST_RELEASE;
          end else begin
            // After recovery actuate either way: the unit decodes the
            // complement as the same operation
            stage_cmd_out <= word_read;
            state_q       <= ST_READ;
          end
        end
        ST_RELEASE: begin
          if (ms_hit) begin
            stage_cmd_out <= word_comp;
            recov_q <= 1'b1;
            state_q <= ST_COMP;
          end
        end
        ST_COMP: begin
          if (ms_hit) begin
            state_q <= ST_CHECK;
          end
        end
        ST_READ: begin
          if (ms_hit) begin
            stage_cmd_out <= `CMD_RESET;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          done_out <= 1'b1;
          busy_out <= 1'b0;
          state_q  <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### ssc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_monitor #(parameter integer CYC_PER_MS = 2) (
  input wire logic mclk_in, nrst_in, start_in, hung_in,
  input wire logic [4:0] stage_sel_in,
  input wire logic [7:0] command_in, feedback_in,
  input wire logic [14:0] stage_cmd_out,
  input wire logic busy_out, done_out, mismatch_out, hung_out, bad_sel_out);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic [14:0] w_q;
  logic [15:0] st_q, rd_q;
  // Age of the word and of the read bit
  always @(posedge mclk_in) begin
    w_q <= stage_cmd_out;
    st_q <= (stage_cmd_out != w_q) ? 16'h0000 : st_q + 16'h0001;
    rd_q <= stage_cmd_out[13] ? rd_q + 16'h0001 : 16'h0000;
  end
  sequence cmd_word_s;
    stage_cmd_out[14:13] == 2'b00 && $onehot(stage_cmd_out[4:0]);
  endsequence
  first_write_a: assert property ($rose(busy_out) |-> cmd_word_s)
    else $error("bad first word");
  settle_a: assert property (
    !w_q[13] && w_q != 15'h0000 && stage_cmd_out != w_q |-> st_q >= 18 * CYC_PER_MS - 1)
    else $error("word left early");
  read_hold_a: assert property ($fell(stage_cmd_out[13]) |-> rd_q >= 25 * CYC_PER_MS)
    else $error("read short");
  reset_word_a: assert property (
    stage_cmd_out[14] |-> stage_cmd_out[13:0] == 14'h0000 ##[0:1] mismatch_out)
    else $error("bad reset word");
  read_word_a: assert property (
    $rose(stage_cmd_out[13]) |-> !stage_cmd_out[14] && stage_cmd_out[12:5] == 8'h00
    && stage_cmd_out[4:0] == w_q[4:0] && $onehot(w_q[4:0])) else $error("bad read word");
  recover_a: assert property ($fell(stage_cmd_out[14]) |-> cmd_word_s)
    else $error("bad recovery word");
  done_pulse_a: assert property (
    done_out |-> stage_cmd_out == 15'h0000 && !busy_out ##1 !done_out) else $error("bad done");
  one_addr_a: assert property (
    !stage_cmd_out[14] && stage_cmd_out != 15'h0000 |-> $onehot(stage_cmd_out[4:0]))
    else $error("address not one-hot");
endmodule
bind stage_switch_command_sequencer ssc_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .start_in(start_in), .hung_in(hung_in),
  .stage_sel_in(stage_sel_in), .command_in(command_in), .feedback_in(feedback_in),
  .stage_cmd_out(stage_cmd_out), .busy_out(busy_out), .done_out(done_out),
  .mismatch_out(mismatch_out), .hung_out(hung_out), .bad_sel_out(bad_sel_out));
`default_nettype wire

// ### relay_unit_model.sv
`timescale 1ns/1ps
`default_nettype none
module relay_unit_model (
  input wire logic mclk_in,
  input wire logic [14:0] word_in,
  input wire logic bad_in,
  output logic [7:0] echo_out);
  logic [7:0] idle_q = 8'h00;
  // Unselected echo lines wander every cycle
  always @(posedge mclk_in) idle_q <= idle_q + 8'h01;
  // Selected unit inverts the command; bad_in spoils bit 0
  assign echo_out = (word_in[4:0] != 5'h00 && word_in[14:13] == 2'b00)
    ? ~word_in[12:5] ^ {7'h00, bad_in} : idle_q;
endmodule
`default_nettype wire

// ### stage_switch_command_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module stage_switch_command_sequencer_bench;
  logic mclk_in = 1'b0, nrst_in = 1'b0, start_in = 1'b0, hung_in = 1'b1, bad = 1'b0;
  logic [4:0] stage_sel_in = 5'h00;
  logic [7:0] command_in = 8'h00, feedback_in;
  logic [14:0] stage_cmd_out, w;
  logic busy_out, done_out, mismatch_out, hung_out, bad_sel_out;
  logic [31:0] seed = 32'h00000E94;
  int bad_count = 0, num_checks = 0, n, k;
  always #5 mclk_in = ~mclk_in;
  stage_switch_command_sequencer #(.CYC_PER_MS(2)) DUT (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .start_in(start_in), .stage_sel_in(stage_sel_in), .command_in(command_in),
    .feedback_in(feedback_in), .hung_in(hung_in), .stage_cmd_out(stage_cmd_out),
    .busy_out(busy_out), .done_out(done_out), .mismatch_out(mismatch_out),
    .hung_out(hung_out), .bad_sel_out(bad_sel_out));
  relay_unit_model unit (.mclk_in(mclk_in), .word_in(stage_cmd_out), .bad_in(bad),
    .echo_out(feedback_in));
  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Expected n-th distinct word of a sequence
  function automatic logic [14:0] exp_w(logic [4:0] s, logic [7:0] c, logic b, int n);
    case (n)
      0: return {2'b00, c, s};
      1: return b ? 15'h4000 : {2'b01, 8'h00, s};
      2: return b ? {2'b00, ~c, s} : 15'h0000;
      3: return b ? {2'b01, 8'h00, s} : 15'h7FFF;
      default: return b ? 15'h0000 : 15'h7FFF;
    endcase
  endfunction
  task automatic pulse(input logic [4:0] s, input logic [7:0] c, input logic b);
    @(posedge mclk_in);
    stage_sel_in <= s;
    command_in <= c;
    bad <= b;
    start_in <= 1'b1;
    @(posedge mclk_in);
    start_in <= 1'b0;
  endtask
  // Next value of the xorshift stream
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction
  // One sequence, every word change compared
  task automatic run(input logic [4:0] s, input logic [7:0] c, input logic b);
    pulse(s, c, b);
    w = 15'h0000;
    n = 0;
    k = 0;
    while (done_out !== 1'b1 && k < 400) begin
      @(posedge mclk_in);
      k++;
      if (stage_cmd_out !== w) begin
        w = stage_cmd_out;
        check(w, exp_w(s, c, b, n));
        n++;
      end
    end
    check(15'(n), b ? 15'h0005 : 15'h0003);
    check({12'h000, hung_out, bad_sel_out, done_out}, 15'h0001);
    check({13'h0000, busy_out, mismatch_out}, {14'h0000, b});
  endtask
  initial begin
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    pulse(5'h01, 8'hA5, 1'b0);
    repeat (4) @(posedge mclk_in);
    check({13'h0000, busy_out, hung_out}, 15'h0001);
    hung_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    pulse(5'h03, 8'h5A, 1'b0);
    repeat (4) @(posedge mclk_in);
    check({13'h0000, busy_out, bad_sel_out}, 15'h0001);
    for (int i = 0; i < 7; i++) begin
      seed = xorshift(seed);
      run(5'h01 << (i % 5), i == 0 ? 8'hFF : (i == 1 ? 8'h00 : seed[7:0]), i[0]);
    end
    finish_test();
  end
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end
endmodule
`default_nettype wire
